// >>> logic/cmed_defs.svh
// Constants for the configuration memory error detector.
`ifndef CMED_DEFS_SVH
`define CMED_DEFS_SVH
`define CMED_SYN_W        32
`define CMED_MSG_W        67
`define CMED_INJ_W        46
`define CMED_INSTR_W      10
`define CMED_CRC_POLY     32'h04C11DB7
`define CMED_CRC_INIT     32'h00000000
`define CMED_UPD_CYCLES   6'h20
`define CMED_GAP_CYCLES   6'h20
`define CMED_CNT_W        6
`define CMED_TYPE_NONE    4'h0
`define CMED_TYPE_SINGLE  4'h1
`define CMED_TYPE_DOUBLE  4'h2
`define CMED_TYPE_OTHER   4'hF
`define CMED_MSG_TYPE_LSB 0
`define CMED_MSG_TYPE_MSB 3
`define CMED_MSG_SYN_LSB  4
`define CMED_MSG_SYN_MSB  35
`define CMED_MSG_FRM_LSB  36
`define CMED_MSG_FRM_MSB  66
`define CMED_FRM_W        31
`define CMED_INJ_PAT_MSB  31
`define CMED_INJ_LOC_LSB  32
`define CMED_INJ_LOC_MSB  41
`define CMED_INJ_TYP_LSB  42
`define CMED_INJ_TYP_MSB  45
`define CMED_INJ_WRD_LSB  34
`define CMED_WIDX_W       8
`define CMED_INSTR_FAULT  10'h015
`define CMED_INSTR_READ   10'h017
`define CMED_DIV_MAX      8
`define CMED_DIV_W        8
`endif

// >>> logic/cmed_pkg.sv
// Types shared by the configuration memory error detector.
package cmed_pkg;
    `include "cmed_defs.svh"
    typedef enum logic [4:0] {
        CMED_IDLE   = 5'h01,
        CMED_CALC   = 5'h02,
        CMED_UPDATE = 5'h04,
        CMED_FLAG   = 5'h08,
        CMED_GAP    = 5'h10
    } cmed_state_t;
endpackage

// >>> logic/cmed_detector.sv
// Frame checker, error message path and fault injection of the detector.
`timescale 1ns/1ps
`include "cmed_defs.svh"
module cmed_detector
    import cmed_pkg::*;
#(
    parameter int DIV_EXP = 0
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       detectEn,
    input  wire logic                       userMode,
    input  wire logic [`CMED_SYN_W-1:0]     frameWord,
    input  wire logic                       frameValid,
    input  wire logic                       frameLast,
    output logic                            frameReady,
    output logic                            errorPin,
    output logic [`CMED_SYN_W-1:0]          syndrome,
    input  wire logic [`CMED_INSTR_W-1:0]   scanInstr,
    input  wire logic                       scanCapture,
    input  wire logic                       scanShift,
    input  wire logic                       scanUpdate,
    input  wire logic                       scanUpdateEn,
    input  wire logic                       scanTdi,
    output logic                            scanTdo,
    input  wire logic                       coreUpdateEn,
    input  wire logic                       coreShift,
    output logic                            coreDout
);
    generate
        if (DIV_EXP < 0 || DIV_EXP > `CMED_DIV_MAX) begin : g_bad_div
            $error("DIV_EXP must lie between 0 and 8");
        end
    endgenerate

    localparam logic [`CMED_DIV_W-1:0] DIV_MASK =
        `CMED_DIV_W'((1 << DIV_EXP) - 1);

    // Bit-serial CRC over one 32-bit word, MSB first.
    function automatic logic [`CMED_SYN_W-1:0] crcWord(
        input logic [`CMED_SYN_W-1:0] crcIn,
        input logic [`CMED_SYN_W-1:0] data);
        logic [`CMED_SYN_W-1:0] c;
        c = crcIn;
        for (int i = `CMED_SYN_W - 1; i >= 0; i--) begin
            if (c[`CMED_SYN_W-1] ^ data[i]) begin
                c = {c[`CMED_SYN_W-2:0], 1'b0} ^ `CMED_CRC_POLY;
            end else begin
                c = {c[`CMED_SYN_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Divider: all checking advances on this one-cycle enable.
    logic [`CMED_DIV_W-1:0] div_reg, div_next;
    logic                   tick;
    always_comb begin
        div_next = div_reg + `CMED_DIV_W'(1);
        tick = ((div_reg & DIV_MASK) == DIV_MASK);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // Frame engine and pin sequencer.
    cmed_state_t                 state_reg, state_next;
    logic [`CMED_CNT_W-1:0]      cnt_reg, cnt_next;
    logic [`CMED_SYN_W-1:0]      crc_reg, crc_next;
    logic [`CMED_SYN_W-1:0]      syn_reg, syn_next;
    logic [`CMED_WIDX_W-1:0]     widx_reg, widx_next;
    logic [`CMED_FRM_W-1:0]      frm_reg, frm_next;
    logic [`CMED_FRM_W-1:0]      errFrm_reg, errFrm_next;
    logic                        hit_reg, hit_next;
    logic [3:0]                  errType_reg, errType_next;
    logic [`CMED_MSG_W-1:0]      emr_reg, emr_next;
    logic                        emrValid_reg, emrValid_next;
    logic                        ready_reg, ready_next;
    logic                        pin_reg, pin_next;
    logic [`CMED_INJ_W-1:0]      injInt_reg;
    logic                        take;
    logic                        injNow;
    logic [3:0]                  injType;
    logic [`CMED_SYN_W-1:0]      word;
    logic [`CMED_SYN_W-1:0]      crcRes;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        crc_next      = crc_reg;
        syn_next      = syn_reg;
        widx_next     = widx_reg;
        frm_next      = frm_reg;
        errFrm_next   = errFrm_reg;
        hit_next      = hit_reg;
        errType_next  = errType_reg;
        emr_next      = emr_reg;
        emrValid_next = 1'b0;
        injType = injInt_reg[`CMED_INJ_TYP_MSB:`CMED_INJ_TYP_LSB];
        take = tick && frameValid && ready_reg;
        // Injection only ever touches frame 0.
        injNow = (frm_reg == '0) && (injType != `CMED_TYPE_NONE) &&
                 (widx_reg ==
                  injInt_reg[`CMED_INJ_LOC_MSB:`CMED_INJ_WRD_LSB]);
        word = injNow ? (frameWord ^ injInt_reg[`CMED_INJ_PAT_MSB:0])
                      : frameWord;
        crcRes = crcWord(crc_reg, word);
        if (take) begin
            crc_next  = crcRes;
            widx_next = widx_reg + `CMED_WIDX_W'(1);
            hit_next  = hit_reg | injNow;
            if (frameLast) begin
                syn_next  = crcRes;
                crc_next  = `CMED_CRC_INIT;
                widx_next = '0;
                hit_next  = 1'b0;
                frm_next  = frm_reg + `CMED_FRM_W'(1);
            end
        end
        if (tick) begin
            case (state_reg)
                CMED_IDLE: begin
                    if (detectEn && userMode) begin
                        state_next = CMED_CALC;
                    end
                end
                CMED_CALC: begin
                    if (take && frameLast && crcRes != '0) begin
                        state_next  = CMED_UPDATE;
                        cnt_next    = '0;
                        errFrm_next = frm_reg;
                        // Real upsets are not located here; only injected
                        // errors carry a known type.
                        errType_next = (hit_reg | injNow) ? injType
                                       : `CMED_TYPE_OTHER;
                    end
                end
                CMED_UPDATE: begin
                    cnt_next = cnt_reg + `CMED_CNT_W'(1);
                    if (cnt_reg == `CMED_UPD_CYCLES - `CMED_CNT_W'(1)) begin
                        emr_next = {errFrm_reg, syn_reg, errType_reg};
                        emrValid_next = 1'b1;
                        state_next = CMED_FLAG;
                    end
                end
                CMED_FLAG: begin
                    if (take && frameLast) begin
                        state_next = CMED_GAP;
                        cnt_next   = '0;
                    end
                end
                CMED_GAP: begin
                    cnt_next = cnt_reg + `CMED_CNT_W'(1);
                    if (cnt_reg == `CMED_GAP_CYCLES - `CMED_CNT_W'(1)) begin
                        state_next = CMED_CALC;
                    end
                end
                default: state_next = CMED_IDLE;
            endcase
        end
        // Frames are stalled while the message is being built.
        ready_next = (state_next == CMED_CALC) ||
                     (state_next == CMED_FLAG);
        pin_next = (state_next == CMED_FLAG);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg    <= CMED_IDLE;
            cnt_reg      <= '0;
            crc_reg      <= `CMED_CRC_INIT;
            syn_reg      <= '0;
            widx_reg     <= '0;
            frm_reg      <= '0;
            errFrm_reg   <= '0;
            hit_reg      <= 1'b0;
            errType_reg  <= `CMED_TYPE_NONE;
            emr_reg      <= '0;
            emrValid_reg <= 1'b0;
            ready_reg    <= 1'b0;
            pin_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            crc_reg      <= crc_next;
            syn_reg      <= syn_next;
            widx_reg     <= widx_next;
            frm_reg      <= frm_next;
            errFrm_reg   <= errFrm_next;
            hit_reg      <= hit_next;
            errType_reg  <= errType_next;
            emr_reg      <= emr_next;
            emrValid_reg <= emrValid_next;
            ready_reg    <= ready_next;
            pin_reg      <= pin_next;
        end
    end

    // Readout and fault injection paths.
    logic [`CMED_MSG_W-1:0] scanUpd_reg, scanUpd_next;
    logic [`CMED_MSG_W-1:0] scanSh_reg, scanSh_next;
    logic [`CMED_MSG_W-1:0] coreUpd_reg, coreUpd_next;
    logic [`CMED_MSG_W-1:0] coreSh_reg, coreSh_next;
    logic [`CMED_INJ_W-1:0] scanInj_reg, scanInj_next;
    logic [`CMED_INJ_W-1:0] injInt_next;
    logic                   tdo_reg, tdo_next;
    logic                   cdo_reg, cdo_next;
    logic                   rdSel, fiSel;

    always_comb begin
        rdSel = (scanInstr == `CMED_INSTR_READ);
        fiSel = (scanInstr == `CMED_INSTR_FAULT);
        scanUpd_next = emrValid_reg ? emr_reg : scanUpd_reg;
        coreUpd_next = emrValid_reg ? emr_reg : coreUpd_reg;
        scanSh_next  = scanSh_reg;
        scanInj_next = scanInj_reg;
        injInt_next  = injInt_reg;
        coreSh_next  = coreSh_reg;
        if (rdSel && scanCapture && scanUpdateEn) begin
            scanSh_next = scanUpd_reg;
        end else if (rdSel && scanShift) begin
            scanSh_next = {scanTdi, scanSh_reg[`CMED_MSG_W-1:1]};
        end
        if (fiSel && scanShift) begin
            scanInj_next = {scanTdi, scanInj_reg[`CMED_INJ_W-1:1]};
        end
        if (fiSel && scanUpdate) begin
            injInt_next = scanInj_reg;
        end
        if (coreUpdateEn) begin
            coreSh_next = coreUpd_reg;
        end else if (coreShift) begin
            coreSh_next = {1'b0, coreSh_reg[`CMED_MSG_W-1:1]};
        end
        tdo_next = fiSel ? scanInj_next[0] : scanSh_next[0];
        cdo_next = coreSh_next[0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scanUpd_reg <= '0;
            scanSh_reg  <= '0;
            coreUpd_reg <= '0;
            coreSh_reg  <= '0;
            scanInj_reg <= '0;
            injInt_reg  <= '0;
            tdo_reg     <= 1'b0;
            cdo_reg     <= 1'b0;
        end else begin
            scanUpd_reg <= scanUpd_next;
            scanSh_reg  <= scanSh_next;
            coreUpd_reg <= coreUpd_next;
            coreSh_reg  <= coreSh_next;
            scanInj_reg <= scanInj_next;
            injInt_reg  <= injInt_next;
            tdo_reg     <= tdo_next;
            cdo_reg     <= cdo_next;
        end
    end

    assign frameReady = ready_reg;
    assign errorPin   = pin_reg;
    assign syndrome   = syn_reg;
    assign scanTdo    = tdo_reg;
    assign coreDout   = cdo_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pin_low_calc_a: assert property (
        (state_reg != CMED_FLAG) |-> !pin_reg)
        else $error("error pin high outside the flag phase");
    pin_nonzero_a: assert property (
        pin_reg |-> (syn_reg != '0))
        else $error("error pin high with zero syndrome");
    pin_after_upd_a: assert property (
        $rose(pin_reg) |-> emrValid_reg &&
        ($past(state_reg) == CMED_UPDATE))
        else $error("error pin rose before the message update");
    upd_len_a: assert property (
        (state_reg == CMED_UPDATE &&
        cnt_reg != `CMED_UPD_CYCLES - `CMED_CNT_W'(1)) |=>
        (state_reg == CMED_UPDATE))
        else $error("message update ended too early");
    scan_copy_a: assert property (
        emrValid_reg |=> (scanUpd_reg == $past(emr_reg)))
        else $error("scan update register missed the message");
    core_copy_a: assert property (
        emrValid_reg |=> (coreUpd_reg == $past(emr_reg)))
        else $error("core update register missed the message");
    scan_hold_a: assert property (
        (!scanShift && !(scanCapture && scanUpdateEn)) |=>
        $stable(scanSh_reg))
        else $error("scan shift register changed without enable");
    inj_load_a: assert property (
        (fiSel && scanUpdate) |=> (injInt_reg == $past(scanInj_reg)))
        else $error("internal fault register not loaded");
    type_code_a: assert property (
        emrValid_reg |->
        (emr_reg[`CMED_MSG_TYPE_MSB:`CMED_MSG_TYPE_LSB] inside
        {`CMED_TYPE_SINGLE, `CMED_TYPE_DOUBLE, `CMED_TYPE_OTHER}))
        else $error("illegal error type in message");
    keep_run_a: assert property (
        (state_reg != CMED_IDLE) |=> (state_reg != CMED_IDLE))
        else $error("checking stopped before reset");
endmodule

// >>> tb/cmed_far_side.sv
// Far side of the detector: frame source, scan host and core reader.
`timescale 1ns/1ps
`include "cmed_defs.svh"
module cmed_far_side (
    input  wire logic   clk,
    input  wire logic   frameReady,
    output logic [31:0] frameWord,
    output logic        frameValid,
    output logic        frameLast,
    output logic [9:0]  scanInstr,
    output logic        scanCapture,
    output logic        scanShift,
    output logic        scanUpdate,
    output logic        scanUpdateEn,
    output logic        scanTdi,
    input  wire logic   scanTdo,
    output logic        coreUpdateEn,
    output logic        coreShift,
    input  wire logic   coreDout
);
    int stalls = 0;
    initial begin
        {frameValid, frameLast, scanCapture, scanShift, scanUpdate} = 5'h00;
        {scanUpdateEn, scanTdi, coreUpdateEn, coreShift} = 4'h0;
        frameWord = 32'h0;
        scanInstr = 10'h000;
    end
    // Idle words show the inverse of the last one, so a word taken
    // outside the handshake corrupts the check instead of passing.
    task automatic send_frame(input logic [31:0] w[$]);
        int n;
        foreach (w[i]) begin
            @(negedge clk);
            frameValid = 1'b1;
            frameWord = w[i];
            frameLast = (i == w.size() - 1);
            n = 0;
            while (frameReady !== 1'b1 && n < 500) begin
                @(negedge clk);
                n++;
            end
            stalls += (n == 500);
            @(posedge clk);
        end
        @(negedge clk);
        {frameValid, frameLast} = 2'b00;
        frameWord = ~frameWord;
    endtask
    task automatic scan_read(input logic en, output logic [66:0] v);
        @(negedge clk);
        scanInstr = `CMED_INSTR_READ;
        scanUpdateEn = en;
        scanCapture = 1'b1;
        scanTdi = 1'b0;
        @(posedge clk);
        for (int k = 0; k < 67; k++) begin
            @(negedge clk);
            {scanCapture, scanUpdateEn} = 2'b00;
            v[k] = scanTdo;
            scanShift = (k < 66);
            scanTdi = (k == 66);
            @(posedge clk);
        end
    endtask
    task automatic scan_fault(input logic [45:0] f);
        for (int k = 0; k < 47; k++) begin
            @(negedge clk);
            scanInstr = `CMED_INSTR_FAULT;
            scanShift = (k < 46);
            scanTdi = (k < 46) ? f[k] : ~f[45];
            scanUpdate = (k == 46);
            @(posedge clk);
        end
        @(negedge clk);
        scanUpdate = 1'b0;
    endtask
    task automatic core_read(output logic [66:0] v);
        @(negedge clk);
        coreUpdateEn = 1'b1;
        @(posedge clk);
        for (int k = 0; k < 67; k++) begin
            @(negedge clk);
            coreUpdateEn = 1'b0;
            v[k] = coreDout;
            coreShift = (k < 66);
            @(posedge clk);
        end
    endtask
endmodule

// >>> tb/cmed_detector_tb.sv
// Self-checking bench of the configuration memory error detector.
`timescale 1ns/1ps
`include "cmed_defs.svh"
module cmed_detector_tb;
    logic [31:0] frameWord, syndrome;
    logic [9:0]  scanInstr;
    logic        clk, rst, detectEn, userMode, frameValid, frameLast;
    logic        frameReady, errorPin, scanCapture, scanShift, scanUpdate;
    logic        scanUpdateEn, scanTdi, scanTdo, coreUpdateEn, coreShift;
    logic        coreDout;
    integer      seed = 32'h0366;
    int          num_errors = 0;
    int          n_checks = 0;
    int          frames = 0;
    cmed_detector #(.DIV_EXP(0)) dut (
        .clk(clk), .rst(rst), .detectEn(detectEn), .userMode(userMode),
        .frameWord(frameWord), .frameValid(frameValid),
        .frameLast(frameLast), .frameReady(frameReady),
        .errorPin(errorPin), .syndrome(syndrome), .scanInstr(scanInstr),
        .scanCapture(scanCapture), .scanShift(scanShift),
        .scanUpdate(scanUpdate), .scanUpdateEn(scanUpdateEn),
        .scanTdi(scanTdi), .scanTdo(scanTdo), .coreUpdateEn(coreUpdateEn),
        .coreShift(coreShift), .coreDout(coreDout));
    cmed_far_side far (
        .clk(clk), .frameReady(frameReady), .frameWord(frameWord),
        .frameValid(frameValid), .frameLast(frameLast),
        .scanInstr(scanInstr), .scanCapture(scanCapture),
        .scanShift(scanShift), .scanUpdate(scanUpdate),
        .scanUpdateEn(scanUpdateEn), .scanTdi(scanTdi), .scanTdo(scanTdo),
        .coreUpdateEn(coreUpdateEn), .coreShift(coreShift),
        .coreDout(coreDout));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string s, input logic [66:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [31:0] crc(input logic [31:0] w[$]);
        logic [31:0] c;
        c = `CMED_CRC_INIT;
        foreach (w[i])
            for (int b = 31; b >= 0; b--)
                c = {c[30:0], 1'b0}
                    ^ ((c[31] ^ w[i][b]) ? `CMED_CRC_POLY : 32'h0);
        return c;
    endfunction
    function automatic logic [66:0] error_message(logic [3:0] t, logic [31:0] s);
        return {frames[30:0], s, t};
    endfunction
    // A frame closes with its own check word, so a clean pass leaves zero.
    task automatic make_frame(output logic [31:0] w[$]);
        w = {};
        repeat (2 + $unsigned($random(seed)) % 5) w.push_back($random(seed));
        w.push_back(crc(w));
    endtask
    task automatic wait_for(input bit rdy, output int n);
        n = 0;
        while ((rdy ? frameReady : errorPin) !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic do_reset();
        @(negedge clk);
        {rst, detectEn, userMode} = 3'b100;
        repeat (6) @(negedge clk);
        check("reset outs", {frameReady, errorPin, syndrome}, 0);
        rst = 1'b0;
        frames = 0;
    endtask
    task automatic good_frame(input logic [31:0] w[$]);
        far.send_frame(w);
        @(negedge clk);
        check("good syndrome", syndrome, 0);
        check("good pin", errorPin, 0);
        frames++;
    endtask
    task automatic run_bad(input logic [31:0] w[$], input logic [31:0] syn,
                           input logic [3:0] t);
        logic [66:0] v;
        int n;
        far.send_frame(w);
        wait_for(1'b0, n);
        check("update cycles", n, `CMED_UPD_CYCLES);
        check("bad syndrome", syndrome, syn);
        // The update registers take the message one clock after the pin.
        @(negedge clk);
        far.scan_read(1'b1, v);
        check("scan message", v, error_message(t, syn));
        far.core_read(v);
        check("core message", v, error_message(t, syn));
        frames++;
    endtask
    task automatic clear_pin();
        logic [31:0] w[$];
        int n;
        check("held high", errorPin, 1);
        make_frame(w);
        far.send_frame(w);
        check("pin drops", errorPin, 0);
        wait_for(1'b1, n);
        check("gap cycles", n, `CMED_GAP_CYCLES);
        check("gap pin", errorPin, 0);
        frames++;
    endtask
    initial begin
        logic [31:0] w[$];
        logic [31:0] wi[$];
        logic [31:0] pat;
        logic [66:0] v;
        int n;
        int loc;
        {rst, detectEn, userMode} = 3'b100;
        do_reset();
        userMode = 1'b1;
        repeat (4) @(negedge clk);
        check("idle ready", frameReady, 0);
        detectEn = 1'b1;
        wait_for(1'b1, n);
        check("start", n <= 2, 1);
        repeat (3) begin
            make_frame(w);
            good_frame(w);
        end
        repeat (2) begin
            make_frame(w);
            w[0] ^= 32'h1 << ($unsigned($random(seed)) % 32);
            run_bad(w, crc(w), `CMED_TYPE_OTHER);
            far.scan_read(1'b0, v);
            check("held shift", v, 0);
            clear_pin();
        end
        for (int t = 0; t < 3; t++) begin
            do_reset();
            make_frame(w);
            loc = $unsigned($random(seed)) % w.size();
            pat = $random(seed) | 32'h1;
            far.scan_fault({t[3:0], loc[7:0], 2'b00, pat});
            {detectEn, userMode} = 2'b11;
            wi = w;
            if (t != 0)
                wi[loc] ^= pat;
            if (crc(wi) == 0)
                good_frame(w);
            else
                run_bad(w, crc(wi), t[3:0]);
        end
        check("frame stalls", far.stalls, 0);
        results();
    end
endmodule
